// ==== rtl/prs_keeper.sv ====
// weak pin keeper: holds last valid level of a pin group
`timescale 1ns/1ps
module prs_keeper #(
   parameter int WIDTH = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pin side
   input wire logic [WIDTH-1:0] pin_level,
   input wire logic [WIDTH-1:0] pin_driven,
   // held level
   output logic [WIDTH-1:0] kept_level
);
   // a driven pin overrides the keeper, an undriven one keeps the last level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kept_level <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (pin_driven[i]) begin
               kept_level[i] <= pin_level[i]; // [R8]
            end
         end
      end
   end
endmodule

// ==== rtl/prs_pkg.sv ====
// constants, register map and types of the reset, sleep and security housekeeping block
// Function
// R1: power-up reset clears every register low
// R2: board holds clock low until setup met
// R3: board keeps clock stable during reset interval
// R4: preload forces each register high or low
// R5: 64-bit user signature always accessible
// R6: security fuse blocks verify and preload
// R7: programmer sets security fuse as last step
// R8: keepers hold undriven pins at last value
// R9: sleep freezes outputs and internal state
// R10: undetermined outputs stay unchanged while asleep
// R11: asleep blocks all inputs except sleep pin
// R12: sleep enabled removes sleep pin array input
// R13: sleep disabled makes shared pin ordinary input
// R14: sleep enable is one separate fuse bit
// R15: sleep release resumes from held state
package prs_pkg;
   // macrocell and pin widths
   localparam int MC_COUNT = 10;
   localparam int IN_COUNT = 10;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PRE_VALUE = 8'h08;
   localparam logic [7:0] OFS_PRE_CMD = 8'h0C;
   localparam logic [7:0] OFS_SIG_LO = 8'h10;
   localparam logic [7:0] OFS_SIG_HI = 8'h14;
   localparam logic [7:0] OFS_PATTERN = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;
   localparam logic [7:0] OFS_FUSE_COUNT = 8'h20;
   // field positions
   localparam int CTRL_SLEEP_EN_BIT = 0;
   localparam int CTRL_SECURE_BIT = 1;
   localparam int STAT_ASLEEP_BIT = 0;
   localparam int STAT_SECURED_BIT = 1;
   localparam int STAT_READY_BIT = 2;
   localparam int PAT_POL_LSB = 0;
   localparam int PAT_OE_LSB = 10;
   localparam int PAT_SHARED_LSB = 20;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [63:0] RST_SIG = 64'h0000_0000_0000_0000;
   // configuration sizes in fuses
   localparam logic [31:0] FUSES_SLEEP_MODE = 32'h0000_1705;
   localparam logic [31:0] FUSES_SIGNATURE_MODE = 32'h0000_1704;
   localparam logic [31:0] FUSES_BASIC_MODE = 32'h0000_16C4;
   // power-up reset interval, longest time rounds down
   localparam int CLK_PERIOD_NS = 8;
   localparam int PR_INTERVAL_MAX_NS = 1000;
   localparam int PR_CYCLES = PR_INTERVAL_MAX_NS / CLK_PERIOD_NS;
   localparam logic [7:0] PR_COUNT_LAST = 8'(PR_CYCLES - 1);
   // ahb transfer type
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // power-up sequence states
   typedef enum logic [1:0] {
      PRS_WAIT = 2'b01,
      PRS_RUN = 2'b10
   } prs_phase_type;
endpackage

// ==== rtl/prs_top.sv ====
// reset, preload, signature, security and sleep housekeeping with ahb-lite registers
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module prs_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // dedicated logic inputs
   input wire logic [prs_pkg::IN_COUNT-1:0] in_pin,
   input wire logic [prs_pkg::IN_COUNT-1:0] in_pin_driven,
   // shared input and sleep pin
   input wire logic shared_input_sleep_pin,
   // bidirectional pins
   input wire logic [prs_pkg::MC_COUNT-1:0] io_in,
   input wire logic [prs_pkg::MC_COUNT-1:0] io_in_driven,
   output logic [prs_pkg::MC_COUNT-1:0] io_out,
   output logic [prs_pkg::MC_COUNT-1:0] io_oe,
   // state seen by the board
   output logic asleep,
   output logic secured
);
   localparam int N = prs_pkg::MC_COUNT;

   // pin synchronisers, first stage read only by the second
   logic [N-1:0] in_meta, in_sync, io_meta, io_sync;
   logic [N-1:0] ind_meta, ind_sync, iod_meta, iod_sync;
   logic sleep_meta, sleep_pin;
   // configuration and state
   logic sleep_enable;
   logic [31:0] pattern;
   logic [63:0] signature;
   logic [N-1:0] pre_value;
   logic [N-1:0] mc_state;
   logic [7:0] pr_count;
   prs_pkg::prs_phase_type phase;
   // kept pin levels and array inputs
   logic [N-1:0] in_kept, io_kept;
   logic [N-1:0] in_gate, io_gate;
   logic shared_gate;
   logic [N-1:0] next_mc_state;
   logic running;
   // bus pipeline
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_ok;
   logic [31:0] next_rdata;
   logic preload_hit;

   // two flops on the logic inputs and their drive flags before any logic sees them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_meta <= '0;
         in_sync <= '0;
         ind_meta <= '0;
         ind_sync <= '0;
      end else begin
         in_meta <= in_pin;
         in_sync <= in_meta;
         ind_meta <= in_pin_driven;
         ind_sync <= ind_meta;
      end
   end

   // same for the bidirectional pins; level and flag move together, so they stay paired
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_meta <= '0;
         io_sync <= '0;
         iod_meta <= '0;
         iod_sync <= '0;
      end else begin
         io_meta <= io_in;
         io_sync <= io_meta;
         iod_meta <= io_in_driven;
         iod_sync <= iod_meta;
      end
   end

   // sleep pin synchroniser, costs two cycles of entry and exit latency
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_meta <= 1'b0;
         sleep_pin <= 1'b0;
      end else begin
         sleep_meta <= shared_input_sleep_pin;
         sleep_pin <= sleep_meta;
      end
   end

   // keepers stay active in sleep, so a released pin never floats
   prs_keeper #(
      .WIDTH(N)
   ) u_in_keeper (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_level(in_sync),
      .pin_driven(ind_sync),
      .kept_level(in_kept)
   );

   // a pin that the device drives counts as driven for its own keeper
   prs_keeper #(
      .WIDTH(N)
   ) u_io_keeper (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_level(io_sync),
      .pin_driven(iod_sync | io_oe), // [R8]
      .kept_level(io_kept)
   );

   // sleep only counts when the configuration bit enables it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         asleep <= 1'b0;
      end else begin
         asleep <= sleep_enable & sleep_pin; // [R9] [R15]
      end
   end

   // power-up interval: array logic waits until it has passed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= prs_pkg::PRS_WAIT;
         pr_count <= '0;
      end else begin
         case (phase)
            prs_pkg::PRS_WAIT: begin
               if (pr_count == prs_pkg::PR_COUNT_LAST) begin
                  phase <= prs_pkg::PRS_RUN;
               end else begin
                  pr_count <= pr_count + 8'h01;
               end
            end
            prs_pkg::PRS_RUN: begin
               phase <= prs_pkg::PRS_RUN;
            end
            default: begin
               phase <= prs_pkg::PRS_WAIT;
            end
         endcase
      end
   end

   // evaluation waits out the power-up interval and halts while asleep
   assign running = (phase == prs_pkg::PRS_RUN) & ~asleep;

   // input blocking while asleep, shared pin routed by the sleep fuse
   always_comb begin
      in_gate = asleep ? '0 : in_kept; // [R11]
      io_gate = asleep ? '0 : io_kept; // [R11]
      // with sleep enabled the shared pin never reaches the array
      shared_gate = (sleep_enable | asleep) ? 1'b0 : sleep_pin; // [R12] [R13]
   end

   // tiny stand-in array: each macrocell mixes its input, io feedback and shared pin
   always_comb begin
      next_mc_state = '0;
      for (int i = 0; i < N; i++) begin
         next_mc_state[i] = in_gate[i] ^ (io_gate[i] & pattern[prs_pkg::PAT_OE_LSB + i])
                          ^ (shared_gate & pattern[prs_pkg::PAT_SHARED_LSB + (i % 10)]);
      end
   end

   // preload is decoded in the data phase of a write to the command word
   assign preload_hit = wr_pend & (wr_addr == prs_pkg::OFS_PRE_CMD) & ~secured; // [R6]

   // macrocell registers: preload wins over evaluation, sleep freezes both
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mc_state <= '0; // [R1]
      end else if (preload_hit & ~asleep) begin
         for (int i = 0; i < N; i++) begin
            if (hwdata[i]) begin
               mc_state[i] <= pre_value[i]; // [R4]
            end
         end
      end else if (running) begin
         mc_state <= next_mc_state; // [R15]
      end
   end

   // output buffers follow register state through the polarity bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_out <= '0;
         io_oe <= '0;
      end else if (!asleep) begin
         io_out <= mc_state ^ pattern[prs_pkg::PAT_POL_LSB +: N]; // [R1]
         io_oe <= pattern[prs_pkg::PAT_OE_LSB +: N];
      end
      // asleep: whatever the buffers show, even an unsettled level, is held [R9] [R10]
   end

   // ahb address phase: accept single word transfers, always zero wait
   assign addr_ok = hsel & hready & (htrans == prs_pkg::HTRANS_NONSEQ);

   // write address held over into the data phase, where hwdata stands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= addr_ok & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // response flags: low in reset, then ready and okay for good
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // read mux, registered at the address phase so data stands in the data phase
   always_comb begin
      next_rdata = prs_pkg::RST_WORD;
      case (haddr[7:0])
         prs_pkg::OFS_CTRL: begin
            next_rdata[prs_pkg::CTRL_SLEEP_EN_BIT] = sleep_enable;
            next_rdata[prs_pkg::CTRL_SECURE_BIT] = secured;
         end
         prs_pkg::OFS_STATUS: begin
            next_rdata[prs_pkg::STAT_ASLEEP_BIT] = asleep;
            next_rdata[prs_pkg::STAT_SECURED_BIT] = secured;
            next_rdata[prs_pkg::STAT_READY_BIT] = (phase == prs_pkg::PRS_RUN);
         end
         prs_pkg::OFS_PRE_VALUE: next_rdata[N-1:0] = pre_value;
         prs_pkg::OFS_SIG_LO: next_rdata = signature[31:0]; // [R5]
         prs_pkg::OFS_SIG_HI: next_rdata = signature[63:32]; // [R5]
         // verify of the pattern reads zero once secured
         prs_pkg::OFS_PATTERN: next_rdata = secured ? prs_pkg::RST_WORD : pattern; // [R6]
         prs_pkg::OFS_STATE: next_rdata[N-1:0] = secured ? '0 : mc_state; // [R6]
         prs_pkg::OFS_FUSE_COUNT: begin
            next_rdata = sleep_enable ? prs_pkg::FUSES_SLEEP_MODE
                                      : prs_pkg::FUSES_SIGNATURE_MODE; // [R14]
         end
         default: next_rdata = prs_pkg::RST_WORD;
      endcase
   end

   // hrdata moves only on a taken read, so it stands through the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= prs_pkg::RST_WORD;
      end else if (addr_ok & ~hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // configuration fuses; the secure bit is one-way and acts at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_enable <= 1'b0;
         secured <= 1'b0;
      end else if (wr_pend & (wr_addr == prs_pkg::OFS_CTRL)) begin
         sleep_enable <= hwdata[prs_pkg::CTRL_SLEEP_EN_BIT]; // [R14]
         // once set no write clears it; programming it last keeps verify possible [R7]
         secured <= secured | hwdata[prs_pkg::CTRL_SECURE_BIT]; // [R6]
      end
   end

   // pattern and preload value; pattern is locked after securing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pattern <= prs_pkg::RST_WORD;
         pre_value <= '0;
      end else if (wr_pend & ~secured) begin
         if (wr_addr == prs_pkg::OFS_PATTERN) begin
            pattern <= hwdata;
         end
         if (wr_addr == prs_pkg::OFS_PRE_VALUE) begin
            pre_value <= hwdata[N-1:0]; // [R4]
         end
      end
   end

   // signature stays writable and readable whether secured or not
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         signature <= prs_pkg::RST_SIG;
      end else if (wr_pend) begin
         if (wr_addr == prs_pkg::OFS_SIG_LO) begin
            signature[31:0] <= hwdata; // [R5]
         end
         if (wr_addr == prs_pkg::OFS_SIG_HI) begin
            signature[63:32] <= hwdata; // [R5]
         end
      end
   end
endmodule

// ==== test/prs_board.sv ====
// board model driving logic inputs, bidirectional pins and the sleep pin
`timescale 1ns/1ps
module prs_board (
   // clock and commands from the bench
   input wire logic hclk,
   input wire logic [9:0] in_val,
   input wire logic [9:0] in_en,
   input wire logic [9:0] io_val,
   input wire logic sleep_level,
   // device side
   input wire logic [9:0] io_out,
   input wire logic [9:0] io_oe,
   output logic [9:0] in_pin,
   output logic [9:0] in_pin_driven,
   output logic [9:0] io_in,
   output logic [9:0] io_in_driven,
   output logic shared_input_sleep_pin
);
   logic [9:0] last = 10'h000;
   // commands arrive just after an edge, so setup is met before the next one
   always @(posedge hclk) begin
      last <= (in_en & in_val) | (~in_en & last);
   end
   // a released pin shows the inverse, only the keeper can hold it
   assign in_pin = (in_en & in_val) | (~in_en & ~last);
   assign in_pin_driven = in_en;
   // wire level: the device wins where it drives
   assign io_in = (io_oe & io_out) | (~io_oe & io_val);
   assign io_in_driven = ~io_oe;
   assign shared_input_sleep_pin = sleep_level;
endmodule

// ==== test/prs_monitor.sv ====
// port checker for the reset, sleep and security block
`timescale 1ns/1ps
module prs_monitor (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins and state
   input wire logic shared_input_sleep_pin,
   input wire logic [prs_pkg::MC_COUNT-1:0] io_out,
   input wire logic [prs_pkg::MC_COUNT-1:0] io_oe,
   input wire logic asleep,
   input wire logic secured
);
   default clocking mon_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // a state read taken while the fuse is set
   sequence locked_read;
      hsel && hready && htrans == prs_pkg::HTRANS_NONSEQ && !hwrite && secured
         && haddr[7:0] == prs_pkg::OFS_STATE;
   endsequence
   // asleep on two edges running, so the later edge must be frozen
   sequence held_two;
      asleep && $past(asleep);
   endsequence
   reset_clear_a: assert property (!$past(hresetn) |->
      (io_out == 10'h000 && io_oe == 10'h000 && !asleep && !secured) [*2])
      else $error("outputs not cleared after reset");
   bus_ready_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
      else $error("bus not ready or not okay");
   lock_sticky_a: assert property (secured |=> secured)
      else $error("security fuse cleared");
   lock_read_a: assert property (locked_read |=> hrdata == 32'h0000_0000)
      else $error("state visible while secured");
   freeze_out_a: assert property (held_two |-> $stable(io_out))
      else $error("outputs moved while asleep");
   freeze_oe_a: assert property (held_two |-> $stable(io_oe))
      else $error("enables moved while asleep");
   sleep_entry_a: assert property ($rose(asleep) |-> $past(shared_input_sleep_pin, 3))
      else $error("sleep entered without pin");
   sleep_exit_a: assert property ($fell(asleep) |-> !$past(shared_input_sleep_pin, 3))
      else $error("sleep left with pin high");
endmodule

// ==== test/prs_top_tb.sv ====
// testbench of the reset, sleep and security block
`timescale 1ns/1ps
module prs_top_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic sleep_level = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [9:0] in_val = 10'h000;
   logic [9:0] in_en = 10'h000;
   logic [9:0] io_val = 10'h000;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, asleep, secured, shared_pin, hit;
   logic [9:0] in_pin, in_pin_driven, io_in, io_in_driven, io_out, io_oe;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #4 hclk = ~hclk;
   prs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_pin(in_pin),
      .in_pin_driven(in_pin_driven), .shared_input_sleep_pin(shared_pin), .io_in(io_in),
      .io_in_driven(io_in_driven), .io_out(io_out), .io_oe(io_oe), .asleep(asleep),
      .secured(secured));
   prs_board board_u (.hclk(hclk), .in_val(in_val), .in_en(in_en), .io_val(io_val),
      .sleep_level(sleep_level), .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin),
      .in_pin_driven(in_pin_driven), .io_in(io_in), .io_in_driven(io_in_driven),
      .shared_input_sleep_pin(shared_pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one single transfer; waits on hready in both phases
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= prs_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      check(rd, exp);
   endtask
   // a preload shows on the pins for one cycle only, so sample a short window;
   // cell 8 stays low, a pulse there would circle its io feedback loop for ever
   task automatic preload_probe();
      xfer(prs_pkg::OFS_PRE_VALUE, 1'b1, 32'h0000_0055);
      xfer(prs_pkg::OFS_PRE_CMD, 1'b1, 32'h0000_03FF);
      hit = 1'b0;
      repeat (6) begin
         @(posedge hclk);
         if (io_out === 10'h05A) hit = 1'b1;
      end
   endtask
   task automatic s_reset();
      check(32'(io_out), 32'h0000_0000);
      rchk(prs_pkg::OFS_STATE, 32'h0000_0000);
      repeat (130) @(posedge hclk);
      rchk(prs_pkg::OFS_STATUS, 32'h0000_0004);
      rchk(prs_pkg::OFS_FUSE_COUNT, prs_pkg::FUSES_SIGNATURE_MODE);
      rchk(8'h40, 32'h0000_0000);
   endtask
   task automatic s_array();
      in_val <= 10'h2A5;
      in_en <= 10'h3FF;
      sleep_level <= 1'b1;
      xfer(prs_pkg::OFS_PATTERN, 1'b1, 32'h0014_000F);
      repeat (10) @(posedge hclk);
      rchk(prs_pkg::OFS_STATE, 32'h0000_02A4);
      check({12'h000, io_oe, io_out}, 32'h0004_02AB);
      in_en <= 10'h000;
      repeat (10) @(posedge hclk);
      rchk(prs_pkg::OFS_STATE, 32'h0000_02A4);
      in_en <= 10'h3FF;
      preload_probe();
      check(32'(hit), 32'h0000_0001);
   endtask
   task automatic s_sleep();
      sleep_level <= 1'b0;
      repeat (8) @(posedge hclk);
      xfer(prs_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
      rchk(prs_pkg::OFS_FUSE_COUNT, prs_pkg::FUSES_SLEEP_MODE);
      sleep_level <= 1'b1;
      repeat (8) @(posedge hclk);
      check(32'(asleep), 32'h0000_0001);
      in_val <= 10'h000;
      repeat (10) @(posedge hclk);
      check(32'(io_out), 32'h0000_02AA);
      rchk(prs_pkg::OFS_STATE, 32'h0000_02A5);
      sleep_level <= 1'b0;
      repeat (8) @(posedge hclk);
      rchk(prs_pkg::OFS_STATE, 32'h0000_0000);
   endtask
   task automatic s_secure();
      // nonzero cells, so a state read that leaks would show
      in_val <= 10'h2A5;
      xfer(prs_pkg::OFS_SIG_LO, 1'b1, 32'hA5A5_0001);
      xfer(prs_pkg::OFS_SIG_HI, 1'b1, 32'h5A5A_0002);
      xfer(prs_pkg::OFS_CTRL, 1'b1, 32'h0000_0002); // fuse set as the final step
      rchk(prs_pkg::OFS_STATUS, 32'h0000_0006);
      rchk(prs_pkg::OFS_PATTERN, 32'h0000_0000);
      rchk(prs_pkg::OFS_STATE, 32'h0000_0000);
      rchk(prs_pkg::OFS_SIG_LO, 32'hA5A5_0001);
      rchk(prs_pkg::OFS_SIG_HI, 32'h5A5A_0002);
      preload_probe();
      check(32'(hit), 32'h0000_0000);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard, far beyond the roughly 250 cycles the run needs
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge hclk); // clock runs steady and unbroken through reset
      hresetn <= 1'b1;
      @(posedge hclk);
      s_reset();
      s_array();
      s_sleep();
      s_secure();
      final_report();
   end
endmodule
bind prs_top prs_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .shared_input_sleep_pin(shared_input_sleep_pin), .io_out(io_out),
   .io_oe(io_oe), .asleep(asleep), .secured(secured));
